// >>> hdl/ocp_pkg.sv
// shared constants for the shunt overcurrent protection pair
// assumes a single 125 MHz clock shared by both ends
package ocp_pkg;
    localparam int CLK_MHZ    = 125;
    localparam int NCH        = 2;
    localparam int CODE_W     = 10;
    localparam int NDRV       = 16;
    localparam int CNT_W      = 16;
    // filter time per filter select code, in ns
    localparam int FILTER_NS [4] = '{1000, 2000, 4000, 8000};
    localparam logic [CNT_W-1:0] FILTER_CYC [4] = '{
        CNT_W'((FILTER_NS[0] * CLK_MHZ + 999) / 1000),
        CNT_W'((FILTER_NS[1] * CLK_MHZ + 999) / 1000),
        CNT_W'((FILTER_NS[2] * CLK_MHZ + 999) / 1000),
        CNT_W'((FILTER_NS[3] * CLK_MHZ + 999) / 1000)};
    // typical gain in V/V per gain code
    localparam logic [7:0] GAIN_VV [4] = '{8'h0A, 8'h14, 8'h28, 8'h50};
    // unidirectional: threshold above half supply, in tenths of supply, per code
    localparam logic [3:0] UNI_TENTHS [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
    // bidirectional: half width in twentieths of supply per code
    localparam logic [3:0] BI_TWENTIETHS [4] = '{4'h2, 4'h4, 4'h5, 4'h6};
    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_CLEAR    = 8'h10;
    // control field positions
    localparam int CTL_GAIN   = 0;
    localparam int CTL_HINT   = 4;
    localparam int CTL_THR    = 6;
    localparam int CTL_DIR    = 10;
    localparam int CTL_FILT   = 12;
    localparam int CTL_CAP    = 16;
    localparam int CTL_CUTOFF = 17;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status bit positions; irq register width
    localparam int ST_ANY   = 0;
    localparam int ST_CH1   = 1;
    localparam int ST_CH2   = 2;
    localparam int ST_ERR   = 3;
    localparam int ST_SHUT  = 4;
    localparam int IRQ_W    = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/ocp_link.sv
// link between the protection device and its host controller
// both ends run on the same clock; no crossing needed
`timescale 1ns/100ps
interface ocp_link;
    import ocp_pkg::*;
    logic [NCH-1:0][1:0] amp_gain_sel;
    logic [NCH-1:0]      shunt_side_hint;
    logic [NCH-1:0][1:0] overcurrent_threshold_sel;
    logic [NCH-1:0]      amp_direction_sel;
    logic [NCH-1:0][1:0] overcurrent_filter_sel;
    logic                output_cap_range_sel;
    logic                overcurrent_cutoff_en;
    logic                clear_status;
    logic                overcurrent_any_flag;
    logic                overcurrent_ch1_flag;
    logic                overcurrent_ch2_flag;
    logic                global_error_flag;
    logic                shutdown_active;

    modport device (
        input  amp_gain_sel, shunt_side_hint, overcurrent_threshold_sel,
        input  amp_direction_sel, overcurrent_filter_sel, output_cap_range_sel,
        input  overcurrent_cutoff_en, clear_status,
        output overcurrent_any_flag, overcurrent_ch1_flag, overcurrent_ch2_flag,
        output global_error_flag, shutdown_active
    );
    modport host (
        output amp_gain_sel, shunt_side_hint, overcurrent_threshold_sel,
        output amp_direction_sel, overcurrent_filter_sel, output_cap_range_sel,
        output overcurrent_cutoff_en, clear_status,
        input  overcurrent_any_flag, overcurrent_ch1_flag, overcurrent_ch2_flag,
        input  global_error_flag, shutdown_active
    );
endinterface

// >>> hdl/ocp_device.sv
// overcurrent protection logic around two current sense amplifiers
// assumes digitised amplifier outputs on clk, full scale = logic supply
`timescale 1ns/100ps
module ocp_device
    import ocp_pkg::*;
#(
    parameter int CH_W  = CODE_W,
    parameter int DRV_N = NDRV
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     nrst,
    // link to host
    ocp_link.device                       lnk,
    // amplifier side
    input  wire logic [NCH-1:0][CH_W-1:0] amp_output,
    output logic      [NCH-1:0][7:0]      amp_gain_vv,
    output logic      [NCH-1:0]           amp_high_side,
    output logic                          amp_cap_large,
    // gate drivers
    input  wire logic [DRV_N-1:0]         gate_cmd,
    output logic      [DRV_N-1:0]         gate_on,
    output logic                          static_discharge
);
    localparam int PW = CH_W + 6;
    localparam logic [PW-1:0] FULL = PW'(1) << CH_W;

    logic [NCH-1:0] raw_trip;
    logic [NCH-1:0] qualified;
    logic [NCH-1:0] ch_flag;
    logic           shut;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [PW-1:0]    scaled10;
        logic [PW-1:0]    scaled20;
        logic [PW-1:0]    uni_lim;
        logic [PW-1:0]    bi_hi;
        logic [PW-1:0]    bi_lo;
        logic [CNT_W-1:0] filt;
        logic [CNT_W-1:0] hi_cnt;
        logic [CNT_W-1:0] lo_cnt;
        logic             absent_long;

        // compare in scaled integers so the tenths and twentieths stay exact
        always_comb begin
            scaled10 = PW'(amp_output[c]) * PW'(10);
            scaled20 = PW'(amp_output[c]) * PW'(20);
            uni_lim  = FULL * PW'(5 + UNI_TENTHS[lnk.overcurrent_threshold_sel[c]]);
            bi_hi    = FULL * PW'(10 + BI_TWENTIETHS[lnk.overcurrent_threshold_sel[c]]);
            bi_lo    = FULL * PW'(10 - BI_TWENTIETHS[lnk.overcurrent_threshold_sel[c]]);
            if (lnk.amp_direction_sel[c]) begin
                raw_trip[c] = (scaled20 > bi_hi) || (scaled20 < bi_lo);
            end else begin
                raw_trip[c] = scaled10 > uni_lim;
            end
        end

        assign filt = FILTER_CYC[lnk.overcurrent_filter_sel[c]];

        // any drop of the comparator restarts the qualification
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                hi_cnt <= '0;
            end else if (!raw_trip[c]) begin
                hi_cnt <= '0;
            end else if (hi_cnt < filt) begin
                hi_cnt <= hi_cnt + CNT_W'(1);
            end
        end

        assign qualified[c] = raw_trip[c] && (hi_cnt >= filt);

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                lo_cnt <= '0;
            end else if (qualified[c]) begin
                lo_cnt <= '0;
            end else if (lo_cnt <= filt) begin
                lo_cnt <= lo_cnt + CNT_W'(1);
            end
        end

        assign absent_long = lo_cnt > filt;

        // a new detection always wins over any clear
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                ch_flag[c] <= 1'b0;
            end else if (qualified[c]) begin
                ch_flag[c] <= 1'b1;
            end else if (!lnk.overcurrent_cutoff_en && absent_long) begin
                ch_flag[c] <= 1'b0;
            end else if (lnk.overcurrent_cutoff_en && lnk.clear_status
                         && !raw_trip[c]) begin
                ch_flag[c] <= 1'b0;
            end
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                amp_gain_vv[c]   <= GAIN_VV[0];
                amp_high_side[c] <= 1'b0;
            end else begin
                amp_gain_vv[c]   <= GAIN_VV[lnk.amp_gain_sel[c]];
                amp_high_side[c] <= lnk.shunt_side_hint[c];
            end
        end
    end

    // shutdown latch; a detection in the clearing cycle keeps it set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shut <= 1'b0;
        end else if (lnk.overcurrent_cutoff_en && |qualified) begin
            shut <= 1'b1;
        end else if (lnk.clear_status || !lnk.overcurrent_cutoff_en) begin
            shut <= 1'b0;
        end
    end

    // without cutoff the gates follow their command unchanged
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gate_on          <= '0;
            static_discharge <= 1'b0;
            amp_cap_large    <= 1'b0;
        end else begin
            gate_on          <= shut ? '0 : gate_cmd;
            static_discharge <= shut;
            amp_cap_large    <= lnk.output_cap_range_sel;
        end
    end

    assign lnk.overcurrent_ch1_flag = ch_flag[0];
    assign lnk.overcurrent_ch2_flag = ch_flag[1];
    assign lnk.overcurrent_any_flag = |ch_flag;
    assign lnk.global_error_flag    = |ch_flag;
    assign lnk.shutdown_active      = shut;
endmodule

// >>> hdl/ocp_host.sv
// host controller: AXI4-Lite register file driving the protection link
// assumes the device end shares clk; flags arrive as same-clock levels
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
module ocp_host
    import ocp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // interrupt
    output logic             irq,
    // link to device
    ocp_link.host            lnk
);
    logic [7:0]       aw_addr;
    logic             aw_held;
    logic [31:0]      w_data;
    logic [31:0]      w_mask;
    logic             w_held;
    logic             do_write;
    logic [31:0]      ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] ev_now;
    logic [IRQ_W-1:0] ev_prev;
    logic [IRQ_W-1:0] w1c;
    logic             clr_pulse;
    logic [31:0]      status;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held  <= 1'b0;
            w_data  <= 32'h0000_0000;
            w_mask  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_mask <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                           {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == OFS_CTRL || aw_addr == OFS_IRQ_STAT ||
                             aw_addr == OFS_IRQ_MASK || aw_addr == OFS_CLEAR)
                            ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl     <= CTRL_RESET;
            irq_mask <= '0;
        end else if (do_write && aw_addr == OFS_CTRL) begin
            ctrl <= (ctrl & ~w_mask) | (w_data & w_mask);
        end else if (do_write && aw_addr == OFS_IRQ_MASK) begin
            irq_mask <= IRQ_W'((irq_mask & ~w_mask[IRQ_W-1:0])
                               | (w_data[IRQ_W-1:0] & w_mask[IRQ_W-1:0]));
        end
    end

    // clearing the device status is a one-cycle strobe on a write of bit 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clr_pulse <= 1'b0;
        end else begin
            clr_pulse <= do_write && aw_addr == OFS_CLEAR && w_mask[0] && w_data[0];
        end
    end

    // rising edges of the ch1, ch2 and shutdown flags; an event beats a same-cycle clear
    assign ev_now = {lnk.shutdown_active, lnk.overcurrent_ch2_flag, lnk.overcurrent_ch1_flag};
    assign w1c = (do_write && aw_addr == OFS_IRQ_STAT)
                 ? (w_data[IRQ_W-1:0] & w_mask[IRQ_W-1:0]) : '0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ev_prev  <= '0;
            irq_stat <= '0;
        end else begin
            ev_prev  <= ev_now;
            irq_stat <= (irq_stat & ~w1c) | (ev_now & ~ev_prev);
        end
    end

    assign irq = |(irq_stat & irq_mask);

    always_comb begin
        status         = 32'h0000_0000;
        status[ST_ANY] = lnk.overcurrent_any_flag;
        status[ST_CH1] = lnk.overcurrent_ch1_flag;
        status[ST_CH2] = lnk.overcurrent_ch2_flag;
        status[ST_ERR] = lnk.global_error_flag;
        status[ST_SHUT]= lnk.shutdown_active;
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_CTRL:     s_axi_rdata <= ctrl;
                OFS_STATUS:   s_axi_rdata <= status;
                OFS_IRQ_STAT: s_axi_rdata <= 32'(irq_stat);
                OFS_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
                OFS_CLEAR:    s_axi_rdata <= 32'h0000_0000;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_ctl
        assign lnk.amp_gain_sel[c]              = ctrl[CTL_GAIN + 2*c +: 2];
        assign lnk.shunt_side_hint[c]           = ctrl[CTL_HINT + c];
        assign lnk.overcurrent_threshold_sel[c] = ctrl[CTL_THR + 2*c +: 2];
        assign lnk.amp_direction_sel[c]         = ctrl[CTL_DIR + c];
        assign lnk.overcurrent_filter_sel[c]    = ctrl[CTL_FILT + 2*c +: 2];
    end
    assign lnk.output_cap_range_sel  = ctrl[CTL_CAP];
    assign lnk.overcurrent_cutoff_en = ctrl[CTL_CUTOFF];
    assign lnk.clear_status          = clr_pulse;
endmodule

// >>> verification/ocp_props.sv
// concurrent checks on the link between protection device and host
// assumes one clock for both ends; instantiated beside the link
`timescale 1ns/100ps
module ocp_props (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link signals
    input wire logic overcurrent_cutoff_en,
    input wire logic clear_status,
    input wire logic overcurrent_any_flag,
    input wire logic overcurrent_ch1_flag,
    input wire logic overcurrent_ch2_flag,
    input wire logic global_error_flag,
    input wire logic shutdown_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_ANY_IS_OR: assert property (overcurrent_any_flag ==
        (overcurrent_ch1_flag | overcurrent_ch2_flag)) else $error("summary flag mismatch");
    AST_ERR_IS_ANY: assert property (global_error_flag == overcurrent_any_flag)
        else $error("global error flag mismatch");
    AST_SHUT_CAUSE: assert property ($rose(shutdown_active) |->
        overcurrent_any_flag && $past(overcurrent_cutoff_en)) else $error("shutdown without cause");
    AST_OFF_RELEASES: assert property (!overcurrent_cutoff_en |=> !shutdown_active)
        else $error("shutdown kept with cutoff off");
    AST_SHUT_HOLDS: assert property (shutdown_active && overcurrent_cutoff_en
        && !clear_status |=> shutdown_active) else $error("shutdown dropped early");
    AST_CLEAR_RELEASES: assert property (clear_status |=>
        !shutdown_active || overcurrent_any_flag) else $error("shutdown kept after clear");
    AST_CH1_LATCHED: assert property (overcurrent_cutoff_en && overcurrent_ch1_flag
        && !clear_status |=> overcurrent_ch1_flag) else $error("ch1 flag not latched");
    AST_CH2_LATCHED: assert property (overcurrent_cutoff_en && overcurrent_ch2_flag
        && !clear_status |=> overcurrent_ch2_flag) else $error("ch2 flag not latched");
    AST_SELF_CLEAR_WAIT: assert property ($rose(overcurrent_ch1_flag)
        && !overcurrent_cutoff_en |=> overcurrent_ch1_flag [*8]) else $error("flag too short");

    cover property ($rose(shutdown_active));
    cover property ($rose(overcurrent_ch2_flag));
    cover property ($fell(shutdown_active) && overcurrent_cutoff_en);
endmodule

// >>> verification/test_shunt_overcurrent_protection.sv
// testbench: host and device joined by the link, host driven over AXI4-Lite
// assumes amplifier codes full scale 1024 and filter codes of 125 << code cycles
`timescale 1ns/100ps
module test_shunt_overcurrent_protection;
    import ocp_pkg::*;
    logic                       clk;
    logic                       nrst;
    logic [NCH-1:0][CODE_W-1:0] amp_output;
    logic [NCH-1:0][7:0]        amp_gain_vv;
    logic [NCH-1:0]             amp_high_side;
    logic                       amp_cap_large;
    logic [NDRV-1:0]            gate_cmd;
    logic [NDRV-1:0]            gate_on;
    logic                       static_discharge;
    logic [7:0]                 s_axi_awaddr;
    logic [7:0]                 s_axi_araddr;
    logic [31:0]                s_axi_wdata;
    logic [31:0]                s_axi_rdata;
    logic [3:0]                 s_axi_wstrb;
    logic [1:0]                 s_axi_bresp;
    logic [1:0]                 s_axi_rresp;
    logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                       s_axi_rvalid, s_axi_rready, irq;
    logic [33:0]                rq[$];
    logic [33:0]                bq[$];
    int                         error_cnt, num_checks, cyc, n, u, b, hw[4];

    ocp_link ocp_link_i ();
    ocp_device ocp_device_i (.clk, .nrst, .lnk(ocp_link_i), .amp_output, .amp_gain_vv,
        .amp_high_side, .amp_cap_large, .gate_cmd, .gate_on, .static_discharge);
    ocp_host ocp_host_i (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .lnk(ocp_link_i));
    ocp_props ocp_props_i (.clk, .nrst,
        .overcurrent_cutoff_en(ocp_link_i.overcurrent_cutoff_en),
        .clear_status(ocp_link_i.clear_status),
        .overcurrent_any_flag(ocp_link_i.overcurrent_any_flag),
        .overcurrent_ch1_flag(ocp_link_i.overcurrent_ch1_flag),
        .overcurrent_ch2_flag(ocp_link_i.overcurrent_ch2_flag),
        .global_error_flag(ocp_link_i.global_error_flag),
        .shutdown_active(ocp_link_i.shutdown_active));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // each channel is released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        bq.push_back(34'(r));
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge clk);
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_ctrl(input int t, input int d, input int f, input int c);
        wr(OFS_CTRL, 32'(t << 6 | t << 8 | d << 11 | f << 12 | f << 14 | c << 17), RESP_OKAY);
    endtask

    task automatic hold(input int v1, input int v2, input int k);
        @(posedge clk);
        amp_output <= {10'(v2), 10'(v1)};
        repeat (k) @(posedge clk);
    endtask

    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), bq.pop_front());
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        void'($urandom(32'h7D2641B4));
        hw = '{2, 4, 5, 6};
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        amp_output = {10'h200, 10'h200};
        gate_cmd = 16'h0000;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(OFS_CTRL, 34'(CTRL_RESET));
        rd(8'h20, {RESP_SLVERR, 32'h0});
        wr(8'h24, 32'h1, RESP_SLVERR);
        wr(OFS_STATUS, 32'h1, RESP_SLVERR);
        chk(34'(amp_gain_vv), 34'h0A0A);
        for (int c = 0; c < 4; c++) begin
            u = $urandom;
            wr(OFS_CTRL, 32'(c | (3 - c) << 2 | (u & 3) << 4 | (u & 4) << 14), RESP_OKAY);
            repeat (3) @(posedge clk);
            chk(34'(amp_gain_vv), 34'({8'(10 << (3 - c)), 8'(10 << c)}));
            chk(34'(amp_high_side), 34'(u & 3));
            chk(34'(amp_cap_large), 34'(u[2]));
        end
        gate_cmd <= 16'($urandom);
        for (int c = 0; c < 4; c++) begin
            u = (5120 + 1024 * c) / 10;
            b = c[0] ? ((10 - hw[c]) * 1024 + 19) / 20 : (10 + hw[c]) * 1024 / 20;
            set_ctrl(c, 1, 0, 0);
            hold(u, b, 140);
            rd(OFS_STATUS, 34'h00);
            hold(u + 1, b, 140);
            rd(OFS_STATUS, 34'h0B);
            chk(34'(gate_on), 34'(gate_cmd));
            chk(34'(static_discharge), 34'h0);
            hold(u, c[0] ? b - 1 : b + 1, 140);
            rd(OFS_STATUS, 34'h0D);
            hold(512, 512, 140);
            rd(OFS_STATUS, 34'h00);
        end
        for (int f = 0; f < 4; f++) begin
            n = 125 << f;
            set_ctrl(0, 0, f, 0);
            hold(600, 512, n - 3);
            hold(512, 512, 1);
            // flag is set at the edge after the count reaches the filter time
            hold(600, 512, n + 1);
            chk(34'(ocp_link_i.overcurrent_ch1_flag), 34'h0);
            @(posedge clk);
            chk(34'(ocp_link_i.overcurrent_ch1_flag), 34'h1);
            hold(512, 512, n + 8);
            chk(34'(ocp_link_i.overcurrent_ch1_flag), 34'h0);
        end
        set_ctrl(0, 0, 0, 1);
        hold(600, 600, 135);
        chk(34'(ocp_link_i.shutdown_active), 34'h1);
        chk(34'(gate_on), 34'h0);
        chk(34'(static_discharge), 34'h1);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        hold(512, 512, 200);
        rd(OFS_STATUS, 34'h1F);
        wr(OFS_CLEAR, 32'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        rd(OFS_STATUS, 34'h00);
        chk(34'(gate_on), 34'(gate_cmd));
        rd(OFS_IRQ_STAT, 34'h7);
        chk(34'(irq), 34'h0);
        wr(OFS_IRQ_MASK, 32'h7, RESP_OKAY);
        chk(34'(irq), 34'h1);
        wr(OFS_IRQ_STAT, 32'h3, RESP_OKAY);
        rd(OFS_IRQ_STAT, 34'h4);
        wr(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
        chk(34'(irq), 34'h0);
        wr(OFS_IRQ_STAT, 32'h4, RESP_OKAY);
        rd(OFS_IRQ_STAT, 34'h0);
        hold(512, 600, 135);
        chk(34'(ocp_link_i.shutdown_active), 34'h1);
        set_ctrl(0, 0, 0, 0);
        repeat (3) @(posedge clk);
        chk(34'(ocp_link_i.shutdown_active), 34'h0);
        chk(34'(gate_on), 34'(gate_cmd));
        final_report();
    end
endmodule
